// file: pkg/timer_pkg.sv
// constants, register map and carrier types of the 16-bit timer compare output stage
package timer_pkg;

  // bus geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;

  // register indices on the plain register port
  localparam logic [ADDR_W-1:0] REG_CTRL    = 3'h0;
  localparam logic [ADDR_W-1:0] REG_COUNT   = 3'h1;
  localparam logic [ADDR_W-1:0] REG_COMPARE = 3'h2;
  localparam logic [ADDR_W-1:0] REG_PORT    = 3'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 3'h4;
  localparam logic [ADDR_W-1:0] REG_MASK    = 3'h5;

  // control register field positions
  localparam int CTRL_WGM_LSB   = 0;
  localparam int CTRL_WGM_W     = 4;
  localparam int CTRL_COM_LSB   = 4;
  localparam int CTRL_COM_W     = 2;
  localparam int CTRL_EN_BIT    = 6;
  localparam int CTRL_FORCE_BIT = 7;

  // port register field positions
  localparam int PORT_VAL_BIT = 0;
  localparam int PORT_DIR_BIT = 1;

  // status and mask layout
  localparam int STAT_OVF_BIT   = 0;
  localparam int STAT_MATCH_BIT = 1;
  localparam int STAT_W         = 2;

  // waveform mode selections that are not pulse width modulation
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_A  = 4'h4;
  localparam logic [3:0] WGM_CTC_I  = 4'hc;

  // compare output mode encodings
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // counter limits and reset values
  localparam logic [DATA_W-1:0] COUNT_MAX     = 16'hffff;
  localparam logic [DATA_W-1:0] COUNT_BOTTOM  = 16'h0000;
  localparam logic [DATA_W-1:0] COUNT_RESET   = 16'h0000;
  localparam logic [DATA_W-1:0] COMPARE_RESET = 16'h0000;
  localparam logic [STAT_W-1:0] STATUS_RESET  = 2'h0;
  localparam logic [STAT_W-1:0] MASK_RESET    = 2'h0;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_type;

  // stored control fields
  typedef struct packed {
    logic                  enable;
    logic [CTRL_COM_W-1:0] com;
    logic [CTRL_WGM_W-1:0] wgm;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = '{enable: 1'b0, com: COM_OFF, wgm: WGM_NORMAL};

endpackage

// file: logic/timer_compare_output.sv
// compare output stage and normal counting mode of a 16-bit timer with register port
//
// Added by the designer: the address-and-strobe port and the placing of the registers.

// Summary of operation
// R01 - reset clears internal compare output bit
// R02 - compare mode field picks action at match
// R03 - nonzero mode field overrides port output value
// R04 - pin drive follows direction bit only
// R05 - mode zero leaves output bit unchanged
// R06 - new mode takes effect at next match
// R07 - force strobe applies action at once, non-pwm
// R08 - counting ignores compare mode field
// R09 - pwm inverts or not; else set/clear/toggle
// R10 - compare mode never touches input capture
// R11 - normal mode always counts up, no clear
// R12 - counter wraps from maximum to zero
// R13 - overflow flag set when counter becomes zero
// R14 - overflow only set by hardware, cleared on service
// R15 - counter writable at any time
// R16 - output bit presettable before pin enabled
// R17 - software avoids reserved mode values
// R18 - force sets no flag, leaves counter alone
// R19 - 16-bit counter advances per enabled tick
module timer_compare_output (
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire timer_pkg::bus_req_type         bus_req,
  input  wire logic                           timer_tick,
  input  wire logic                           ovf_int_ack,
  output logic      [timer_pkg::DATA_W-1:0]   rdata,
  output logic                                irq,
  output logic                                pin_out,
  output logic                                pin_oe
);
  import timer_pkg::*;

  // stored state
  ctrl_type               ctrl;
  logic [DATA_W-1:0]      counter_value;
  logic [DATA_W-1:0]      compare_value;
  logic                   port_value;
  logic                   pin_direction_bit;
  logic [STAT_W-1:0]      status;
  logic [STAT_W-1:0]      mask;
  logic                   compare_output_bit;
  logic                   write_block;

  // next values and decode
  ctrl_type               next_ctrl;
  logic [DATA_W-1:0]      next_counter;
  logic                   next_block;
  logic                   next_oc;
  logic [STAT_W-1:0]      next_status;
  logic [STAT_W-1:0]      status_set;
  logic [STAT_W-1:0]      status_clr;
  logic [DATA_W-1:0]      read_word;
  logic                   wr_ctrl;
  logic                   wr_count;
  logic                   wr_compare;
  logic                   wr_port;
  logic                   wr_status;
  logic                   wr_mask;
  logic                   force_compare_strobe;
  logic                   force_fire;
  logic [CTRL_COM_W-1:0]  force_com;
  logic [CTRL_WGM_W-1:0]  force_wgm;
  logic                   pwm_mode;
  logic                   force_pwm;
  logic                   tick_en;
  logic                   compare_hit;
  logic                   wrap_hit;
  logic                   ovf_set;

  // compare output action; pwm mode here only sets or clears at the match,
  // the opposite edge at top belongs to the pwm modes left out of this block
  function automatic logic oc_action(input logic cur, input logic [1:0] com, input logic pwm);
    logic res;
    res = cur;
    case (com)
      COM_OFF:    res = cur;                    // [R05]
      COM_TOGGLE: res = pwm ? cur : ~cur;       // [R09] reserved under pwm, held
      COM_CLEAR:  res = 1'b0;                   // [R09]
      COM_SET:    res = 1'b1;                   // [R09]
      default:    res = cur;
    endcase
    return res;
  endfunction

  function automatic logic is_pwm(input logic [3:0] wgm);
    return !((wgm == WGM_NORMAL) || (wgm == WGM_CTC_A) || (wgm == WGM_CTC_I));
  endfunction

  // address decode of the write strobe
  assign wr_ctrl    = bus_req.wr && (bus_req.addr == REG_CTRL);
  assign wr_count   = bus_req.wr && (bus_req.addr == REG_COUNT);
  assign wr_compare = bus_req.wr && (bus_req.addr == REG_COMPARE);
  assign wr_port    = bus_req.wr && (bus_req.addr == REG_PORT);
  assign wr_status  = bus_req.wr && (bus_req.addr == REG_STATUS);
  assign wr_mask    = bus_req.wr && (bus_req.addr == REG_MASK);

  // control word; force bit is a strobe and is never stored
  assign next_ctrl.enable = wr_ctrl ? bus_req.wdata[CTRL_EN_BIT] : ctrl.enable;
  assign next_ctrl.com    = wr_ctrl ? bus_req.wdata[CTRL_COM_LSB +: CTRL_COM_W] : ctrl.com;
  assign next_ctrl.wgm    = wr_ctrl ? bus_req.wdata[CTRL_WGM_LSB +: CTRL_WGM_W] : ctrl.wgm;

  // force uses the mode fields written in the same word, so one write both configures and fires
  assign force_compare_strobe = wr_ctrl && bus_req.wdata[CTRL_FORCE_BIT];
  assign force_com            = bus_req.wdata[CTRL_COM_LSB +: CTRL_COM_W];
  assign force_wgm            = bus_req.wdata[CTRL_WGM_LSB +: CTRL_WGM_W];
  assign force_pwm            = is_pwm(force_wgm);
  assign force_fire           = force_compare_strobe && !force_pwm;   // [R07]
  assign pwm_mode             = is_pwm(ctrl.wgm);

  // counting depends on the tick and the enable only, never on the mode fields
  assign tick_en      = timer_tick && ctrl.enable;                     // [R19] [R08]
  assign compare_hit  = tick_en && (counter_value == compare_value) && !write_block;
  assign wrap_hit     = tick_en && (counter_value == COUNT_MAX);
  assign ovf_set      = wrap_hit && !wr_count;                         // [R13]
  assign next_counter = wr_count ? bus_req.wdata :                     // [R15]
                        tick_en  ? counter_value + 16'h0001 :          // [R11] [R12]
                        counter_value;

  // a counter write hides the match of the following tick, as a preset equal
  // to the compare value would otherwise fire at once
  assign next_block = wr_count ? 1'b1 : (tick_en ? 1'b0 : write_block);

  // output bit: force beats a match landing in the same cycle; the match reads
  // the mode field held at that moment, so a new mode waits for the next match
  assign next_oc = force_fire  ? oc_action(compare_output_bit, force_com, force_pwm) :   // [R07] [R16]
                   compare_hit ? oc_action(compare_output_bit, ctrl.com, pwm_mode) :     // [R02] [R06]
                   compare_output_bit;

  // sticky event bits; force never reaches the match flag
  assign status_set[STAT_OVF_BIT]   = ovf_set;                         // [R14]
  assign status_set[STAT_MATCH_BIT] = compare_hit;                     // [R18]
  assign status_clr[STAT_OVF_BIT]   = (wr_status && bus_req.wdata[STAT_OVF_BIT]) || ovf_int_ack;  // [R14]
  assign status_clr[STAT_MATCH_BIT] = wr_status && bus_req.wdata[STAT_MATCH_BIT];

  // set wins over clear so an event in the clearing cycle survives
  generate
    for (genvar i = 0; i < STAT_W; i++) begin : g_status
      assign next_status[i] = status_set[i] || (status[i] && !status_clr[i]);
    end
  endgenerate

  // read mux; unmapped indices read zero
  always_comb begin
    read_word = '0;
    case (bus_req.addr)
      REG_CTRL:    read_word = {8'h00, 1'b0, ctrl.enable, ctrl.com, ctrl.wgm};
      REG_COUNT:   read_word = counter_value;
      REG_COMPARE: read_word = compare_value;
      REG_PORT:    read_word = {14'h0, pin_direction_bit, port_value};
      REG_STATUS:  read_word = {14'h0, status};
      REG_MASK:    read_word = {14'h0, mask};
      default:     read_word = '0;
    endcase
  end

  // timer core registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl               <= CTRL_RESET;
      counter_value      <= COUNT_RESET;
      compare_value      <= COMPARE_RESET;
      write_block        <= 1'b0;
      compare_output_bit <= 1'b0;                                      // [R01]
    end else begin
      ctrl               <= next_ctrl;
      counter_value      <= next_counter;
      compare_value      <= wr_compare ? bus_req.wdata : compare_value;
      write_block        <= next_block;
      compare_output_bit <= next_oc;
    end
  end

  // port, status and mask registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_value        <= 1'b0;
      pin_direction_bit <= 1'b0;
      status            <= STATUS_RESET;
      mask              <= MASK_RESET;
    end else begin
      port_value        <= wr_port ? bus_req.wdata[PORT_VAL_BIT] : port_value;
      pin_direction_bit <= wr_port ? bus_req.wdata[PORT_DIR_BIT] : pin_direction_bit;
      status            <= next_status;
      mask              <= wr_mask ? bus_req.wdata[STAT_W-1:0] : mask;
    end
  end

  // registered outputs; the pin lags its sources by one clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata   <= '0;
      irq     <= 1'b0;
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      rdata   <= bus_req.rd ? read_word : '0;
      irq     <= |(status & mask);
      pin_out <= (ctrl.com != COM_OFF) ? compare_output_bit : port_value;   // [R03]
      pin_oe  <= pin_direction_bit;                                        // [R04]
    end
  end

  // the mode field feeds only the output path above; no capture logic reads it [R10]

  // ---- checks ----
  property p_reset_clears_oc;
    @(posedge clk) sys_rst |=> (compare_output_bit == 1'b0);
  endproperty
  a_reset_clears_oc: assert property (p_reset_clears_oc) else $error("output bit not cleared by reset"); // [R01]

  property p_mode_zero_holds;
    @(posedge clk) disable iff (sys_rst)
      (compare_hit && (ctrl.com == COM_OFF) && !force_compare_strobe) |=> $stable(compare_output_bit);
  endproperty
  a_mode_zero_holds: assert property (p_mode_zero_holds) else $error("mode zero changed output bit"); // [R05]

  property p_toggle_on_match;
    @(posedge clk) disable iff (sys_rst)
      (compare_hit && !pwm_mode && (ctrl.com == COM_TOGGLE) && !force_compare_strobe)
        |=> (compare_output_bit != $past(compare_output_bit));
  endproperty
  a_toggle_on_match: assert property (p_toggle_on_match) else $error("toggle at match missing"); // [R02]

  property p_clear_on_match;
    @(posedge clk) disable iff (sys_rst)
      (compare_hit && (ctrl.com == COM_CLEAR) && !force_compare_strobe) |=> !compare_output_bit;
  endproperty
  a_clear_on_match: assert property (p_clear_on_match) else $error("clear at match missing"); // [R09]

  property p_force_set;
    @(posedge clk) disable iff (sys_rst)
      (force_compare_strobe && !force_pwm && (force_com == COM_SET)) |=> compare_output_bit ##1 pin_oe == $past(pin_direction_bit);
  endproperty
  a_force_set: assert property (p_force_set) else $error("force did not set output bit"); // [R07]

  property p_force_no_side_effect;
    @(posedge clk) disable iff (sys_rst)
      (force_compare_strobe && !compare_hit && !tick_en && !wr_count)
        |=> (status[STAT_MATCH_BIT] == $past(status[STAT_MATCH_BIT])) && $stable(counter_value);
  endproperty
  a_force_no_side_effect: assert property (p_force_no_side_effect) else $error("force touched flag or counter"); // [R18]

  property p_pin_override;
    @(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> pin_out == (($past(ctrl.com) != COM_OFF) ? $past(compare_output_bit) : $past(port_value));
  endproperty
  a_pin_override: assert property (p_pin_override) else $error("pin source wrong"); // [R03]

  property p_pin_direction;
    @(posedge clk) disable iff (sys_rst) !$past(sys_rst) |-> (pin_oe == $past(pin_direction_bit));
  endproperty
  a_pin_direction: assert property (p_pin_direction) else $error("pin drive not from direction bit"); // [R04]

  property p_wrap_sets_flag;
    @(posedge clk) disable iff (sys_rst)
      (wrap_hit && !wr_count) |=> (counter_value == COUNT_BOTTOM) && status[STAT_OVF_BIT];
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("wrap or overflow flag wrong"); // [R12] [R13]

  property p_overflow_sticky;
    @(posedge clk) disable iff (sys_rst)
      (status[STAT_OVF_BIT] && !status_clr[STAT_OVF_BIT]) |=> status[STAT_OVF_BIT];
  endproperty
  a_overflow_sticky: assert property (p_overflow_sticky) else $error("overflow flag lost"); // [R14]

  property p_count_up;
    @(posedge clk) disable iff (sys_rst)
      (tick_en && !wr_count && (ctrl.wgm == WGM_NORMAL) && (counter_value != COUNT_MAX))
        |=> (counter_value == $past(counter_value) + 16'h0001);
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step by one"); // [R11] [R19]

  property p_count_write;
    @(posedge clk) disable iff (sys_rst) wr_count |=> (counter_value == $past(bus_req.wdata));
  endproperty
  a_count_write: assert property (p_count_write) else $error("counter write lost"); // [R15]

  property p_irq_level;
    @(posedge clk) disable iff (sys_rst) !$past(sys_rst) |-> (irq == |($past(status) & $past(mask)));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  // p_oc_holds, p_count_hold and p_overflow_by_wrap below name the only events allowed to move what they watch
  property p_oc_holds;
    @(posedge clk) disable iff (sys_rst)
      (!force_fire && !compare_hit)
        |=> $stable(compare_output_bit);
  endproperty
  a_oc_holds: assert property (p_oc_holds) else $error("output bit moved without event"); // [R06]

  property p_force_clear;
    @(posedge clk) disable iff (sys_rst)
      (force_fire && (force_com == COM_CLEAR))
        |=> !compare_output_bit;
  endproperty
  a_force_clear: assert property (p_force_clear) else $error("force did not clear output bit"); // [R07]

  property p_force_toggle;
    @(posedge clk) disable iff (sys_rst)
      (force_fire && (force_com == COM_TOGGLE))
        |=> (compare_output_bit != $past(compare_output_bit));
  endproperty
  a_force_toggle: assert property (p_force_toggle) else $error("force did not toggle output bit"); // [R07]

  property p_force_refused_pwm;
    @(posedge clk) disable iff (sys_rst)
      (force_compare_strobe && force_pwm && !compare_hit)
        |=> $stable(compare_output_bit);
  endproperty
  a_force_refused_pwm: assert property (p_force_refused_pwm) else $error("force acted in pwm mode"); // [R07]

  property p_match_sets_flag;
    @(posedge clk) disable iff (sys_rst)
      compare_hit
        |=> status[STAT_MATCH_BIT];
  endproperty
  a_match_sets_flag: assert property (p_match_sets_flag) else $error("match flag not set"); // [R02]

  property p_count_any_mode;
    @(posedge clk) disable iff (sys_rst)
      (tick_en && !wr_count && (ctrl.wgm != WGM_NORMAL))
        |=> (counter_value == $past(counter_value) + 16'h0001);
  endproperty
  a_count_any_mode: assert property (p_count_any_mode) else $error("counting depends on mode"); // [R08]

  property p_count_hold;
    @(posedge clk) disable iff (sys_rst)
      (!tick_en && !wr_count)
        |=> $stable(counter_value);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved without tick"); // [R19]

  property p_match_no_clear;
    @(posedge clk) disable iff (sys_rst)
      (compare_hit && !wr_count)
        |=> (counter_value == $past(counter_value) + 16'h0001);
  endproperty
  a_match_no_clear: assert property (p_match_no_clear) else $error("match cleared the counter"); // [R11]

  property p_overflow_by_wrap;
    @(posedge clk) disable iff (sys_rst)
      $rose(status[STAT_OVF_BIT])
        |-> $past(ovf_set);
  endproperty
  a_overflow_by_wrap: assert property (p_overflow_by_wrap) else $error("overflow flag set without wrap"); // [R14]

  property p_overflow_service;
    @(posedge clk) disable iff (sys_rst)
      (ovf_int_ack && !ovf_set)
        |=> !status[STAT_OVF_BIT];
  endproperty
  a_overflow_service: assert property (p_overflow_service) else $error("service left overflow flag"); // [R14]

  property p_match_flag_clear;
    @(posedge clk) disable iff (sys_rst)
      (wr_status && bus_req.wdata[STAT_MATCH_BIT] && !compare_hit)
        |=> !status[STAT_MATCH_BIT];
  endproperty
  a_match_flag_clear: assert property (p_match_flag_clear) else $error("match flag not cleared");

  property p_rdata_idle;
    @(posedge clk) disable iff (sys_rst)
      !bus_req.rd
        |=> (rdata == '0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

  c_overflow:   cover property (@(posedge clk) disable iff (sys_rst) ovf_set ##1 irq);
  c_toggle:     cover property (@(posedge clk) disable iff (sys_rst) compare_hit && ctrl.com == COM_TOGGLE);
  c_force:      cover property (@(posedge clk) disable iff (sys_rst) force_fire ##2 pin_out && pin_oe);
  c_blocked:    cover property (@(posedge clk) disable iff (sys_rst)
                                tick_en && write_block && counter_value == compare_value);
  c_refused:    cover property (@(posedge clk) disable iff (sys_rst) force_compare_strobe && force_pwm);

endmodule

// file: dv/pin_load_model.sv
// external load on the compare output pin: a pull-down that sets the level when the pin floats
module pin_load_model (
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // released pin is pulled low, so a stale driven value never shows through
  assign pin_level = pin_oe ? pin_out : 1'b0;
endmodule

// file: dv/compare_output_and_normal_mode_tb.sv
// self-checking bench for the timer compare output stage and normal counting mode
module compare_output_and_normal_mode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;

  logic              clk;
  logic              sys_rst;
  logic              timer_tick;
  logic              ovf_int_ack;
  bus_req_type       bus_req;
  logic [DATA_W-1:0] rdata;
  logic              irq;
  logic              pin_out;
  logic              pin_oe;
  logic              pin_level;
  int                n_mismatch;
  int                comparisons;

  timer_compare_output dut (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .bus_req     (bus_req),
    .timer_tick  (timer_tick),
    .ovf_int_ack (ovf_int_ack),
    .rdata       (rdata),
    .irq         (irq),
    .pin_out     (pin_out),
    .pin_oe      (pin_oe)
  );

  pin_load_model load (
    .pin_out   (pin_out),
    .pin_oe    (pin_oe),
    .pin_level (pin_level)
  );

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      timer_tick <= 1'b1;
      @(posedge clk);
      timer_tick <= 1'b0;
    end
  endtask

  // pin and irq are registered, so let them land before looking
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // enabled normal mode; callers keep off mode codes reserved for the mode
  function automatic logic [DATA_W-1:0] ctrl_word(input logic [1:0] com, input logic frc);
    ctrl_word = '0;
    ctrl_word[CTRL_EN_BIT] = 1'b1;
    ctrl_word[CTRL_COM_LSB +: CTRL_COM_W] = com;
    ctrl_word[CTRL_FORCE_BIT] = frc;
  endfunction

  task automatic t_reset;
    #1 check(16'(pin_oe), 16'h0000);
    rd_check(REG_CTRL, 16'h0000);
    rd_check(REG_STATUS, 16'h0000);
    // showing the bit through the pin proves it came out of reset low
    wr(REG_CTRL, ctrl_word(COM_TOGGLE, 1'b0));
    wr(REG_PORT, 16'h0002);
    settle;
    check(16'(pin_oe), 16'h0001);
    check(16'(pin_level), 16'h0000);
  endtask

  task automatic t_preset;
    wr(REG_PORT, 16'h0000);
    wr(REG_CTRL, ctrl_word(COM_SET, 1'b1));
    settle;
    check(16'(pin_oe), 16'h0000);
    check(16'(pin_level), 16'h0000);
    wr(REG_PORT, 16'h0002);
    settle;
    check(16'(pin_level), 16'h0001);
    rd_check(REG_STATUS, 16'h0000);
    rd_check(REG_COUNT, 16'h0000);
  endtask

  task automatic t_force_table;
    logic [1:0] coms [4];
    logic       exps [4];
    coms = '{COM_CLEAR, COM_TOGGLE, COM_TOGGLE, COM_SET};
    exps = '{1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL, ctrl_word(coms[i], 1'b1));
      settle;
      check(16'(pin_out), 16'(exps[i]));
    end
    // mode zero hands the pin back to the port value and leaves the bit alone
    wr(REG_CTRL, ctrl_word(COM_OFF, 1'b1));
    settle;
    check(16'(pin_out), 16'h0000);
    wr(REG_CTRL, ctrl_word(COM_TOGGLE, 1'b0));
    settle;
    check(16'(pin_out), 16'h0001);
  endtask

  task automatic t_match;
    wr(REG_COMPARE, 16'h0005);
    wr(REG_COUNT, 16'h0003);
    wr(REG_CTRL, ctrl_word(COM_CLEAR, 1'b0));
    settle;
    check(16'(pin_out), 16'h0001);
    tick(2);
    settle;
    check(16'(pin_out), 16'h0001);
    rd_check(REG_COUNT, 16'h0005);
    tick(1);
    settle;
    check(16'(pin_out), 16'h0000);
    rd_check(REG_STATUS, 16'h0002);
    rd_check(REG_COUNT, 16'h0006);
    wr(REG_STATUS, 16'h0002);
    rd_check(REG_STATUS, 16'h0000);
  endtask

  task automatic t_overflow;
    wr(REG_MASK, 16'h0001);
    wr(REG_CTRL, ctrl_word(COM_SET, 1'b0));
    wr(REG_COUNT, 16'hfffe);
    tick(1);
    rd_check(REG_COUNT, 16'hffff);
    rd_check(REG_STATUS, 16'h0000);
    tick(1);
    rd_check(REG_COUNT, 16'h0000);
    rd_check(REG_STATUS, 16'h0001);
    check(16'(irq), 16'h0001);
    @(posedge clk);
    ovf_int_ack <= 1'b1;
    @(posedge clk);
    ovf_int_ack <= 1'b0;
    rd_check(REG_STATUS, 16'h0000);
    settle;
    check(16'(irq), 16'h0000);
    // a counter write mid-run is taken as is
    tick(1);
    wr(REG_COUNT, 16'h1234);
    rd_check(REG_COUNT, 16'h1234);
    tick(1);
    rd_check(REG_COUNT, 16'h1235);
  endtask

  task automatic t_unmapped;
    wr(3'h6, 16'hffff);
    rd_check(3'h6, 16'h0000);
    rd_check(3'h7, 16'h0000);
    rd_check(REG_CTRL, ctrl_word(COM_SET, 1'b0));
  endtask

  // blocked preset, toggle at a match, mode zero at a match
  task automatic t_match_modes;
    wr(REG_COMPARE, 16'h0010);
    wr(REG_CTRL, ctrl_word(COM_TOGGLE, 1'b0));
    wr(REG_COUNT, 16'h0010);
    tick(1);
    rd_check(REG_STATUS, 16'h0000);
    wr(REG_COUNT, 16'h000f);
    tick(2);
    settle;
    check(16'(pin_out), 16'h0001);
    wr(REG_CTRL, ctrl_word(COM_OFF, 1'b0));
    wr(REG_COUNT, 16'h000f);
    tick(2);
    settle;
    check(16'(pin_out), 16'h0000);
    wr(REG_CTRL, ctrl_word(COM_TOGGLE, 1'b0));
    settle;
    check(16'(pin_out), 16'h0001);
    rd_check(REG_COUNT, 16'h0011);
    rd_check(REG_STATUS, 16'h0002);
  endtask

  // force is refused in a pwm mode, counting goes on the same
  task automatic t_pwm_force;
    wr(REG_CTRL, ctrl_word(COM_CLEAR, 1'b1) | 16'h0001);
    settle;
    check(16'(pin_out), 16'h0001);
    tick(1);
    rd_check(REG_COUNT, 16'h0012);
    rd_check(REG_CTRL, ctrl_word(COM_CLEAR, 1'b0) | 16'h0001);
  endtask

  // a reset in mid-run must drop a set output bit
  task automatic t_mid_reset;
    wr(REG_CTRL, ctrl_word(COM_SET, 1'b1));
    settle;
    check(16'(pin_level), 16'h0001);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1 check(16'(pin_oe), 16'h0000);
    wr(REG_CTRL, ctrl_word(COM_TOGGLE, 1'b0));
    wr(REG_PORT, 16'h0002);
    settle;
    check(16'(pin_oe), 16'h0001);
    check(16'(pin_level), 16'h0000);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    test_done;
  end

  initial begin
    sys_rst = 1'b1;
    timer_tick = 1'b0;
    ovf_int_ack = 1'b0;
    bus_req = '0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_preset;
    t_force_table;
    t_match;
    t_overflow;
    t_unmapped;
    t_match_modes;
    t_pwm_force;
    t_mid_reset;
    test_done;
  end
endmodule
